// ==== logic/sep_map.svh ====
// Opcode, status bit and timing constants for the SPI EEPROM command block
`ifndef SEP_MAP_SVH
`define SEP_MAP_SVH

// Opcode upper nibble and low three bits; bit 3 is ignored
`define SEP_OP_HI 4'h0
`define SEP_OP_LATCH_SET 3'h6
`define SEP_OP_LATCH_CLR 3'h4
`define SEP_OP_STAT_RD 3'h5
`define SEP_OP_STAT_WR 3'h1
`define SEP_OP_ARR_RD 3'h3
`define SEP_OP_ARR_WR 3'h2

// Status byte bit positions
`define SEP_ST_BUSY 0
`define SEP_ST_WEL 1
`define SEP_ST_BG_LO 2
`define SEP_ST_BG_HI 3
`define SEP_ST_GPE 7
`define SEP_ST_ALL_BUSY 8'hFF

// Array geometry
`define SEP_ADDR_W 11
`define SEP_PAGE_W 5

// Pin idle levels {cs_n, sck, si, hold_n, wp_n}
`define SEP_PINS_IDLE 5'h13

// Self-timed write cycle
`define SEP_WC_TIME_MS 5
`define SEP_MCLK_HZ 25000000

`endif

// ==== logic/sep_pkg.sv ====
// Types shared by the SPI EEPROM command block
`default_nettype none
package sep_pkg;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic hold_n;
        logic wp_n;
    } sep_pins_t;

    typedef enum logic [2:0] {
        st_idle, st_op, st_ahi, st_alo, st_din, st_srin, st_out, st_ign
    } sep_state_t;

    typedef enum logic [2:0] {
        cmd_lset, cmd_lclr, cmd_srd, cmd_swr, cmd_ard, cmd_awr, cmd_bad
    } sep_cmd_t;

endpackage : sep_pkg
`default_nettype wire

// ==== logic/sep_sync.sv ====
// Two-stage synchroniser for pin inputs
`default_nettype none
module sep_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] q_d;

    always_comb begin
        meta_d = d;
        q_d = meta_q;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            meta_q <= RST;
            q <= RST;
        end else begin
            meta_q <= meta_d;
            q <= q_d;
        end
    end
endmodule : sep_sync
`default_nettype wire

// ==== logic/sep_wc_timer.sv ====
// Self-timed write cycle timer: busy level and one-cycle done pulse
`default_nettype none
module sep_wc_timer #(
    parameter int CYCLES = 125000
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic start,
    output logic busy,
    output logic done
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic busy_d;
    logic done_d;

    always_comb begin
        cnt_d = cnt_q;
        busy_d = busy;
        done_d = 1'b0;
        if (start && !busy) begin
            cnt_d = CW'(CYCLES - 1);
            busy_d = 1'b1;
        end else if (busy) begin
            if (cnt_q == '0) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q - CW'(1);
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_q <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            busy <= busy_d;
            done <= done_d;
        end
    end
endmodule : sep_wc_timer
`default_nettype wire

// ==== logic/sep_top.sv ====
// SPI EEPROM slave: opcode decode, write latch, status and write protection
// Function
// - First eight bits after select falls are the opcode for this select.
// - Unknown opcode: ignore input, float output until select falls again.
// - While deselected, ignore input and float the serial output.
// - Pause keeps state, floats output, ignores input and clocks, then resumes.
// - Guard pin low with guard enable set refuses status writes.
// - Guard pin low during select abandons status write; running cycle unaffected.
// - Guard enable clear makes the guard pin irrelevant.
// - Bytes shift MSB first; each instruction starts at select falling.
// - Decode latch set, latch clear, status read; bit 3 ignored.
// - Decode status write, array read, array write; bit 3 ignored.
// - Write latch is clear after power-up.
// - Latch clear disables programming regardless of the guard pin.
// - Status bit 0 is one during a write cycle.
// - Bit 1 latch, bits 2-3 block level, bit 7 guard enable.
// - Bits 4-6 read zero; all bits read one while busy.
// - Block level protects none, upper quarter, upper half or whole array.
// - Protect bits are stored by a latched, timed, busy-showing write cycle.
// - Hardware protection still allows writes outside protected blocks.
// - While busy, only the status read is accepted.
// - Write latch clears when a write cycle completes.
// - Guard enable cannot be cleared while the guard pin stays low.
// - Array write without latch is ignored until select rises.
`include "sep_map.svh"
`default_nettype none
module sep_top #(
    parameter int ADDR_W = `SEP_ADDR_W,
    parameter int WC_CYCLES = `SEP_WC_TIME_MS * (`SEP_MCLK_HZ / 1000)
) (
    input wire logic mclk,
    input wire logic reset,
    input wire sep_pkg::sep_pins_t pins,
    output logic so_out,
    output logic so_oe_n
);
    import sep_pkg::*;

    localparam int PW = `SEP_PAGE_W;
    localparam int PAGE = 1 << PW;
    localparam int DEPTH = 1 << ADDR_W;

    sep_pins_t pins_s;
    logic sel;
    logic sck_s;
    logic si_s;
    logic hold_s;
    logic wp_s;
    logic sck_prev_q;
    logic sel_prev_q;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic cs_fall;
    logic live;
    logic accept;
    logic hwp;
    logic byte_evt;
    logic op_evt;
    logic [7:0] byte_in;
    logic [7:0] status_val;
    logic [7:0] arr_byte;
    sep_cmd_t opc;

    sep_state_t state_q, state_d;
    sep_cmd_t cmd_q, cmd_d;
    logic [2:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [7:0] out_q, out_d;
    logic [7:0] obyte;
    logic [2:0] ocnt_q, ocnt_d;
    logic wel_q, wel_d;
    logic gpe_q, gpe_d;
    logic [1:0] bg_q, bg_d;
    logic [2:0] sr_new_q, sr_new_d;
    logic sr_full_q, sr_full_d;
    logic gabort_q, gabort_d;
    logic [PAGE-1:0] pvalid_q, pvalid_d;
    logic wkind_q, wkind_d;
    logic so_d;
    logic so_oe_n_d;
    logic pause_q, pause_d;
    logic start_sr;
    logic start_arr;
    logic pb_we;
    logic [PW-1:0] pb_idx;
    logic wc_busy;
    logic wc_done;

    logic [7:0] mem [0:DEPTH-1];
    logic [7:0] pbuf [0:PAGE-1];

    function automatic sep_cmd_t decode(input logic [7:0] b);
        sep_cmd_t c;
        c = cmd_bad;
        if (b[7:4] == `SEP_OP_HI) begin
            case (b[2:0])
                `SEP_OP_LATCH_SET: c = cmd_lset;
                `SEP_OP_LATCH_CLR: c = cmd_lclr;
                `SEP_OP_STAT_RD: c = cmd_srd;
                `SEP_OP_STAT_WR: c = cmd_swr;
                `SEP_OP_ARR_RD: c = cmd_ard;
                `SEP_OP_ARR_WR: c = cmd_awr;
                default: c = cmd_bad;
            endcase
        end
        return c;
    endfunction : decode

    function automatic logic prot(input logic [ADDR_W-1:0] a, input logic [1:0] bg);
        logic p;
        p = 1'b0;
        case (bg)
            2'h1: p = (a[ADDR_W-1:ADDR_W-2] == 2'h3);
            2'h2: p = a[ADDR_W-1];
            2'h3: p = 1'b1;
            default: p = 1'b0;
        endcase
        return p;
    endfunction : prot

    sep_sync #(.W(5), .RST(`SEP_PINS_IDLE)) u_sync (
        .mclk(mclk),
        .reset(reset),
        .d(pins),
        .q(pins_s)
    );

    sep_wc_timer #(.CYCLES(WC_CYCLES)) u_wc (
        .mclk(mclk),
        .reset(reset),
        .start(start_sr || start_arr),
        .busy(wc_busy),
        .done(wc_done)
    );

    assign sel = !pins_s.cs_n;
    assign sck_s = pins_s.sck;
    assign si_s = pins_s.si;
    assign hold_s = pins_s.hold_n;
    assign wp_s = pins_s.wp_n;
    assign sck_rise = sck_s && !sck_prev_q;
    assign sck_fall = !sck_s && sck_prev_q;
    assign cs_fall = sel && !sel_prev_q;
    assign cs_rise = !sel && sel_prev_q;
    assign live = sel && !pause_q;
    assign accept = (state_q != st_ign) && (state_q != st_out) && (state_q != st_idle);
    assign hwp = gpe_q && !wp_s;
    assign byte_in = {sh_q[6:0], si_s};
    assign byte_evt = live && sck_rise && accept && (cnt_q == 3'h7);
    assign op_evt = byte_evt && (state_q == st_op);
    assign opc = decode(byte_in);
    assign arr_byte = mem[addr_q];
    assign pb_idx = addr_q[PW-1:0];
    assign status_val = wc_busy ? `SEP_ST_ALL_BUSY : {gpe_q, 3'h0, bg_q, wel_q, 1'b0};

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        cmd_d = cmd_q;
        addr_d = addr_q;
        out_d = out_q;
        ocnt_d = ocnt_q;
        wel_d = wel_q;
        gpe_d = gpe_q;
        bg_d = bg_q;
        sr_new_d = sr_new_q;
        sr_full_d = sr_full_q;
        gabort_d = gabort_q;
        pvalid_d = pvalid_q;
        wkind_d = wkind_q;
        so_d = so_out;
        pause_d = pause_q;
        start_sr = 1'b0;
        start_arr = 1'b0;
        pb_we = 1'b0;
        obyte = 8'h00;
        if (wc_done) begin
            wel_d = 1'b0;
            if (wkind_q) begin
                gpe_d = sr_new_q[2];
                bg_d = sr_new_q[1:0];
            end
        end
        if (!sel) begin
            pause_d = 1'b0;
        end else if (!sck_s) begin
            pause_d = !hold_s;
        end
        if (cs_fall) begin
            gabort_d = hwp;
        end else if (sel && hwp) begin
            gabort_d = 1'b1;
        end
        if (!sel) begin
            state_d = st_idle;
            if (cs_rise) begin
                if (state_q == st_srin && sr_full_q && cnt_q == 3'h0 && wel_q && !gabort_q
                    && !hwp) begin
                    start_sr = 1'b1;
                    wkind_d = 1'b1;
                end
                if (state_q == st_din && cnt_q == 3'h0 && (|pvalid_q)) begin
                    start_arr = 1'b1;
                    wkind_d = 1'b0;
                end
            end
        end else if (cs_fall) begin
            state_d = st_op;
            cnt_d = 3'h0;
            sr_full_d = 1'b0;
        end else if (live && sck_rise && accept) begin
            sh_d = byte_in;
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
                case (state_q)
                    st_op: begin
                        cmd_d = opc;
                        state_d = st_ign;
                        if (!wc_busy || opc == cmd_srd) begin
                            case (opc)
                                cmd_lset: wel_d = 1'b1;
                                cmd_lclr: wel_d = 1'b0;
                                cmd_srd: begin
                                    state_d = st_out;
                                    ocnt_d = 3'h0;
                                end
                                cmd_swr: state_d = wel_q ? st_srin : st_ign;
                                cmd_ard: state_d = st_ahi;
                                cmd_awr: begin
                                    state_d = wel_q ? st_ahi : st_ign;
                                    pvalid_d = '0;
                                end
                                default: state_d = st_ign;
                            endcase
                        end
                    end
                    st_ahi: begin
                        addr_d = ADDR_W'({byte_in, 8'h00});
                        state_d = st_alo;
                    end
                    st_alo: begin
                        addr_d = {addr_q[ADDR_W-1:8], byte_in};
                        state_d = (cmd_q == cmd_ard) ? st_out : st_din;
                        ocnt_d = 3'h0;
                    end
                    st_din: begin
                        if (!prot(addr_q, bg_q)) begin
                            pb_we = 1'b1;
                            pvalid_d[pb_idx] = 1'b1;
                        end
                        addr_d[PW-1:0] = addr_q[PW-1:0] + PW'(1);
                    end
                    st_srin: begin
                        sr_new_d = {byte_in[`SEP_ST_GPE], byte_in[`SEP_ST_BG_HI],
                                    byte_in[`SEP_ST_BG_LO]};
                        sr_full_d = 1'b1;
                    end
                    default: state_d = state_q;
                endcase
            end
        end else if (live && sck_fall && state_q == st_out) begin
            if (ocnt_q == 3'h0) begin
                obyte = (cmd_q == cmd_srd) ? status_val : arr_byte;
            end else begin
                obyte = out_q;
            end
            so_d = obyte[7];
            out_d = {obyte[6:0], 1'b0};
            ocnt_d = ocnt_q + 3'h1;
            if (ocnt_q == 3'h7 && cmd_q == cmd_ard) begin
                addr_d = addr_q + ADDR_W'(1);
            end
        end
        so_oe_n_d = !(state_d == st_out && sel && !pause_d);
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sck_prev_q <= 1'b0;
            sel_prev_q <= 1'b0;
            state_q <= st_idle;
            cmd_q <= cmd_bad;
            cnt_q <= 3'h0;
            sh_q <= 8'h00;
            addr_q <= '0;
            out_q <= 8'h00;
            ocnt_q <= 3'h0;
            wel_q <= 1'b0;
            gpe_q <= 1'b0;
            bg_q <= 2'h0;
            sr_new_q <= 3'h0;
            sr_full_q <= 1'b0;
            gabort_q <= 1'b0;
            pvalid_q <= '0;
            wkind_q <= 1'b0;
            so_out <= 1'b0;
            so_oe_n <= 1'b1;
            pause_q <= 1'b0;
        end else begin
            sck_prev_q <= sck_s;
            sel_prev_q <= sel;
            state_q <= state_d;
            cmd_q <= cmd_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            addr_q <= addr_d;
            out_q <= out_d;
            ocnt_q <= ocnt_d;
            wel_q <= wel_d;
            gpe_q <= gpe_d;
            bg_q <= bg_d;
            sr_new_q <= sr_new_d;
            sr_full_q <= sr_full_d;
            gabort_q <= gabort_d;
            pvalid_q <= pvalid_d;
            wkind_q <= wkind_d;
            so_out <= so_d;
            so_oe_n <= so_oe_n_d;
            pause_q <= pause_d;
        end
    end

    // Page bytes are committed only when the timed cycle ends, so a torn select writes nothing
    always_ff @(posedge mclk) begin
        if (pb_we) begin
            pbuf[pb_idx] <= byte_in;
        end
        if (wc_done && !wkind_q) begin
            for (int i = 0; i < PAGE; i++) begin
                if (pvalid_q[i]) begin
                    mem[{addr_q[ADDR_W-1:PW], PW'(i)}] <= pbuf[i];
                end
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence s_bad_op;
        op_evt && opc == cmd_bad && !wc_busy;
    endsequence

    AST_BAD_OP_FLOAT: assert property (s_bad_op |=> state_q == st_ign ##1 so_oe_n)
        else $error("invalid opcode not ignored");
    AST_FLOAT_IDLE: assert property ((state_q != st_out || pause_q) |-> so_oe_n)
        else $error("serial output driven outside read");
    AST_PAUSE_FREEZE: assert property (pause_q && sck_rise |=> $stable(sh_q) && $stable(cnt_q))
        else $error("input shifted during pause");
    AST_SR_GUARD: assert property (start_sr |-> !hwp && !gabort_q && wel_q)
        else $error("status write started while guarded");
    AST_SR_FREE: assert property (cs_rise && state_q == st_srin && sr_full_q && cnt_q == 3'h0
        && wel_q && !gpe_q |-> start_sr)
        else $error("status write refused with guard disabled");
    AST_LSET_X: assert property (op_evt && byte_in == 8'h0E && !wc_busy |=> wel_q)
        else $error("latch set with bit 3 not decoded");
    AST_LCLR: assert property (op_evt && opc == cmd_lclr && !wc_busy |=> !wel_q)
        else $error("latch clear did not clear");
    AST_BUSY_START: assert property ((start_sr || start_arr) |-> wel_q ##1 wc_busy)
        else $error("write cycle without latch or busy");
    AST_STAT_BUSY: assert property (wc_busy |-> status_val == `SEP_ST_ALL_BUSY)
        else $error("status not all ones while busy");
    AST_PROT_DROP: assert property (state_q == st_din && byte_evt && prot(addr_q, bg_q)
        |=> $stable(pvalid_q))
        else $error("protected byte queued");
    AST_BUSY_IGN: assert property (op_evt && wc_busy && opc != cmd_srd |=> state_q == st_ign)
        else $error("instruction accepted while busy");
    // A latch set finishing in the cycle-end cycle wins over the clear
    AST_WEL_DONE: assert property (wc_done && !(op_evt && opc == cmd_lset) |=> !wel_q)
        else $error("latch not cleared after write cycle");
endmodule : sep_top
`default_nettype wire

// ==== dv/sep_master.sv ====
// Host-side SPI mode 0 master model driving the EEPROM pins
`default_nettype none
module sep_master (
    input wire logic mclk,
    input wire logic so_out,
    input wire logic so_oe_n,
    output var sep_pkg::sep_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ns;
    import sep_pkg::*;

    logic oe_pause;

    initial pins = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

    // Half of the 320 ns link period
    task automatic half();
        repeat (4) @(negedge mclk);
    endtask : half

    // pause entered and left with sck low
    task automatic pause();
        // Let the last falling sck settle before the pause pin moves
        @(negedge mclk);
        pins.hold_n = 1'b0;
        half();
        repeat (2) begin
            pins.sck = 1'b1;
            pins.si = ~pins.si;
            half();
            pins.sck = 1'b0;
            half();
        end
        oe_pause = so_oe_n;
        pins.hold_n = 1'b1;
        half();
    endtask : pause

    // drive in low phase, sample while high
    task automatic frame(input logic [7:0] tx [$], input int hb,
                         output logic [7:0] rx [$], output logic [7:0] oe [$]);
        int n;
        logic [7:0] r;
        logic [7:0] e;
        n = 0;
        rx = {};
        oe = {};
        pins.cs_n = 1'b0;
        foreach (tx[k]) begin
            for (int i = 7; i >= 0; i--) begin
                if (n == hb) pause();
                pins.si = tx[k][i];
                half();
                pins.sck = 1'b1;
                // Output moves on the third mclk rise after a fall, so the mid-high point is settled
                repeat (2) @(negedge mclk);
                // Undriven line reads as the inverse of the last bit, so stale data cannot pass
                r[i] = so_oe_n ? !so_out : so_out;
                e[i] = so_oe_n;
                repeat (2) @(negedge mclk);
                pins.sck = 1'b0;
                n++;
            end
            rx.push_back(r);
            oe.push_back(e);
        end
        half();
        pins.cs_n = 1'b1;
        // released line shows no stale value
        pins.si = ~pins.si;
        half();
    endtask : frame
endmodule : sep_master
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the SPI EEPROM command block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import sep_pkg::*;

    // Short write cycle keeps busy long enough for one status read
    localparam int WC = 200;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic so_out;
    logic so_oe_n;
    sep_pins_t pins;
    int error_cnt = 0;
    int n_tests = 0;
    logic [7:0] q [$];
    logic [7:0] o [$];
    logic [7:0] v;
    logic [7:0] ops [4] = '{8'h0E, 8'h04, 8'h06, 8'h0C};
    logic [7:0] exp_st [4] = '{8'h02, 8'h00, 8'h02, 8'h00};
    logic [7:0] bad [2] = '{8'h15, 8'h07};
    int hbs [2] = '{4, 11};

    always #20 mclk = ~mclk;

    sep_top #(.ADDR_W(11), .WC_CYCLES(WC)) dut (
        .mclk(mclk),
        .reset(reset),
        .pins(pins),
        .so_out(so_out),
        .so_oe_n(so_oe_n)
    );

    sep_master host (
        .mclk(mclk),
        .so_out(so_out),
        .so_oe_n(so_oe_n),
        .pins(pins)
    );

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check_byte

    task automatic check_bit(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic cmd(input logic [7:0] op);
        host.frame('{op}, -1, q, o);
    endtask : cmd

    task automatic rd(output logic [7:0] s);
        host.frame('{8'h05, 8'h00}, -1, q, o);
        s = q[1];
    endtask : rd

    task automatic finish_test();
        $display("Errors %0d of %0d checks", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    // Polls busy a bounded number of times
    task automatic wait_ready();
        logic [7:0] s;
        for (int i = 0; i < 10; i++) begin
            rd(s);
            if (s[0] === 1'b0) return;
        end
        error_cnt++;
        $display("CHECK FAILED busy wait expected 0 seen 1");
        finish_test();
    endtask : wait_ready

    initial begin
        repeat (6) @(negedge mclk);
        reset = 1'b0;
        repeat (4) @(negedge mclk);
        host.frame('{8'h0D, 8'h00}, -1, q, o);
        check_byte("status after reset", 8'h00, q[1]);
        check_byte("status drive", 8'h00, o[1]);
        repeat (2) @(negedge mclk);
        check_bit("idle output", 1'b1, so_oe_n);
        foreach (ops[i]) begin
            cmd(ops[i]);
            rd(v);
            check_byte("latch flag", exp_st[i], v);
        end
        foreach (bad[i]) begin
            host.frame('{bad[i], 8'h00}, -1, q, o);
            check_byte("invalid drive", 8'hFF, o[1]);
        end
        host.frame('{8'h01, 8'h8C}, -1, q, o);
        rd(v);
        check_byte("write without latch", 8'h00, v);
        cmd(8'h06);
        host.frame('{8'h02, 8'h06, 8'h00, 8'hA5}, -1, q, o);
        wait_ready();
        cmd(8'h06);
        host.frame('{8'h01, 8'hFF}, -1, q, o);
        rd(v);
        check_byte("busy status", 8'hFF, v);
        wait_ready();
        rd(v);
        check_byte("stored status", 8'h8C, v);
        cmd(8'h06);
        fork
            host.frame('{8'h01, 8'h00}, -1, q, o);
            begin
                repeat (80) @(negedge mclk);
                host.pins.wp_n = 1'b0;
                repeat (16) @(negedge mclk);
                host.pins.wp_n = 1'b1;
            end
        join
        rd(v);
        check_byte("guard pulse", 8'h8E, v);
        host.pins.wp_n = 1'b0;
        host.frame('{8'h01, 8'h00}, -1, q, o);
        host.pins.wp_n = 1'b1;
        rd(v);
        check_byte("guard held", 8'h8E, v);
        host.frame('{8'h01, 8'h00}, -1, q, o);
        wait_ready();
        rd(v);
        check_byte("guard released", 8'h00, v);
        host.pins.wp_n = 1'b0;
        cmd(8'h06);
        host.frame('{8'h01, 8'h04}, -1, q, o);
        wait_ready();
        host.pins.wp_n = 1'b1;
        rd(v);
        check_byte("guard disabled", 8'h04, v);
        cmd(8'h06);
        host.frame('{8'h02, 8'h05, 8'hFF, 8'h22}, -1, q, o);
        cmd(8'h06);
        wait_ready();
        rd(v);
        check_byte("latch after cycle", 8'h04, v);
        cmd(8'h06);
        host.frame('{8'h02, 8'h06, 8'h00, 8'h3C}, -1, q, o);
        rd(v);
        check_byte("no cycle for protected write", 8'h06, v);
        cmd(8'h04);
        wait_ready();
        host.frame('{8'h02, 8'h05, 8'hFF, 8'h99}, -1, q, o);
        wait_ready();
        host.frame('{8'h03, 8'h05, 8'hFF, 8'h00, 8'h00}, -1, q, o);
        check_byte("unprotected byte", 8'h22, q[3]);
        check_byte("protected byte", 8'hA5, q[4]);
        foreach (hbs[i]) begin
            host.frame('{8'h05, 8'h00}, hbs[i], q, o);
            check_bit("output in pause", 1'b1, host.oe_pause);
            check_byte("status across pause", 8'h04, q[1]);
        end
        finish_test();
    end
endmodule : testbench
`default_nettype wire
